// >>> hdl/rps_ref_select.sv
// pll reference select, power, deglitch and status pin routing control
//
// Functional notes
// - register bit picks primary or secondary reference
// - manual choice from register bit or pin
// - automatic switchover powers both reference inputs
// - revert to primary unless stay bit set
// - power bits gate inputs, automatic mode overrides
// - differential bit makes one differential reference
// - eeprom enable routes eeprom status to pin
// - crystal amplifier runs only while enabled
module rps_ref_select #(
    parameter int DEGLITCH_CYCLES = rps_pkg::DEGLITCH_CYC        // stable cycles before switching
) (
    input  wire logic                        clk_sys,            // 20 mhz system clock
    input  wire logic                        srst,               // synchronous reset, high
    input  wire logic                        regWrEn,            // register write strobe
    input  wire logic                        regRdEn,            // register read strobe
    input  wire logic [rps_pkg::ADDR_W-1:0]  regAddr,            // register address
    input  wire logic [rps_pkg::DATA_W-1:0]  regWrData,          // register write data
    output logic      [rps_pkg::DATA_W-1:0]  regRdData,          // registered read data
    input  wire logic                        refSelPin,          // external reference choice pin
    input  wire logic                        primaryGoodPin,     // primary reference status good
    input  wire logic                        secondaryGoodPin,   // secondary reference status good
    input  wire logic                        eepromStatusIn,     // eeprom status level
    input  wire logic                        statusSelIn,        // level chosen by status field
    output rps_pkg::rps_front_t              front,              // reference front end controls
    output logic                             statusPin,          // status output pin level
    output logic                             deglitchBusy        // a switch is waiting to settle
);

    typedef enum logic { RPS_ON_PRIMARY, RPS_ON_SECONDARY } rps_auto_t;

    localparam int CNT_W = $clog2(DEGLITCH_CYCLES + 1);

    initial
    begin
        if (DEGLITCH_CYCLES < 1)
            $error("rps_ref_select: DEGLITCH_CYCLES must be at least one");
    end

    rps_pkg::rps_ref_ctrl_t refCtrl_q;                           // reference input control
    rps_pkg::rps_stat_osc_t statOsc_q;                           // status and oscillator control
    logic [2:0]             pinSync;                             // retimed select and status pins
    logic                   selPin;                              // retimed select pin
    logic                   primaryGood;                         // retimed primary status
    logic                   secondaryGood;                       // retimed secondary status
    rps_auto_t              autoState_q;                         // automatic switchover state
    rps_auto_t              autoState_d;                         // next automatic state
    logic                   sel_q;                               // reference actually fed to pll
    logic [CNT_W-1:0]       stableCnt_q;                         // cycles the new choice has held
    logic                   manualSel;                           // manual mode choice
    logic                   wantSel;                             // choice before deglitch
    logic                   hitCtrl;                             // address decode, control
    logic                   hitStat;                             // address decode, status
    logic [7:0]             rdMux;                               // read data before the register

    // pins come from other domains, retime them before use
    rps_sync #(
        .WIDTH   (3)
    ) u_sync (
        .clk_sys (clk_sys),
        .srst    (srst),
        .asyncIn ({refSelPin, primaryGoodPin, secondaryGoodPin}),
        .syncOut (pinSync)
    );

    assign selPin        = pinSync[2];
    assign primaryGood   = pinSync[1];
    assign secondaryGood = pinSync[0];

    // address decode
    assign hitCtrl = (regAddr == rps_pkg::REF_CTRL_ADDR);
    assign hitStat = (regAddr == rps_pkg::STAT_OSC_ADDR);
    assign rdMux   = hitCtrl ? refCtrl_q :
                     hitStat ? statOsc_q : rps_pkg::UNMAPPED_DATA;

    // register writes; software owns mode ordering, the logic does not police it
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            refCtrl_q <= rps_pkg::REF_CTRL_RST;
            statOsc_q <= rps_pkg::STAT_OSC_RST;
        end
        else if (regWrEn)
        begin
            if (hitCtrl)
                refCtrl_q <= regWrData;
            if (hitStat)
                statOsc_q <= regWrData;
        end
    end

    // read data held until the next read
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            regRdData <= rps_pkg::UNMAPPED_DATA;
        else if (regRdEn)
            regRdData <= rdMux;
    end

    // revertive or non-revertive automatic switching
    always_comb
    begin
        autoState_d = autoState_q;
        case (autoState_q)
            RPS_ON_PRIMARY:
            begin
                // leave only if the other reference can take over
                if (!primaryGood && secondaryGood)
                    autoState_d = RPS_ON_SECONDARY;
            end
            RPS_ON_SECONDARY:
            begin
                if (!refCtrl_q.staySecondary && primaryGood)
                    autoState_d = RPS_ON_PRIMARY;
            end
            default:
                autoState_d = RPS_ON_PRIMARY;
        endcase
    end

    // automatic state idles on primary while automatic mode is off
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            autoState_q <= RPS_ON_PRIMARY;
        else if (!refCtrl_q.autoEn)
            autoState_q <= RPS_ON_PRIMARY;
        else
            autoState_q <= autoState_d;
    end

    // manual choice, then automatic, then differential forces the single input
    assign manualSel = refCtrl_q.usePin ? selPin : refCtrl_q.selSecondary;
    assign wantSel   = refCtrl_q.diffEn ? 1'b0 :
                       refCtrl_q.autoEn ? (autoState_q == RPS_ON_SECONDARY) :
                       manualSel;

    // deglitch: a new choice must hold before the pll sees it, trading latency
    // for freedom from runt edges when the selection bounces
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            sel_q       <= 1'b0;
            stableCnt_q <= '0;
        end
        else if (wantSel == sel_q)
            stableCnt_q <= '0;
        else if (refCtrl_q.deglitchDis)
        begin
            sel_q       <= wantSel;
            stableCnt_q <= '0;
        end
        else if (stableCnt_q >= CNT_W'(DEGLITCH_CYCLES - 1))
        begin
            sel_q       <= wantSel;
            stableCnt_q <= '0;
        end
        else
            stableCnt_q <= stableCnt_q + CNT_W'(1);
    end

    assign deglitchBusy = (wantSel != sel_q) && !refCtrl_q.deglitchDis;

    // power: automatic mode powers both inputs regardless of the bits
    assign front.pwrPrimary   = refCtrl_q.autoEn | refCtrl_q.pwrPrimary;
    assign front.pwrSecondary = refCtrl_q.autoEn | refCtrl_q.pwrSecondary;
    assign front.diffMode     = refCtrl_q.diffEn;
    assign front.selSecondary = sel_q;
    assign front.xtalAmpEn    = statOsc_q.xtalAmpEn;

    // status pin: eeprom status wins over the status field selection
    assign statusPin = statOsc_q.eepromStatus ? eepromStatusIn : statusSelIn;

endmodule

// >>> hdl/rps_sync.sv
// two-flop synchroniser bank for pins from outside the clk_sys domain
module rps_sync #(
    parameter int WIDTH = 3                                      // number of pins
) (
    input  wire logic             clk_sys,                       // system clock
    input  wire logic             srst,                          // synchronous reset
    input  wire logic [WIDTH-1:0] asyncIn,                       // raw pin levels
    output logic      [WIDTH-1:0] syncOut                        // retimed levels
);

    initial
    begin
        if (WIDTH < 1)
            $error("rps_sync: WIDTH must be at least one");
    end

    // one independent pair of flops per pin; first stage feeds only the second
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        logic stage1_q;                                          // metastability catcher
        logic stage2_q;                                          // settled level

        always_ff @(posedge clk_sys)
        begin
            if (srst)
            begin
                stage1_q <= 1'b0;
                stage2_q <= 1'b0;
            end
            else
            begin
                stage1_q <= asyncIn[i];
                stage2_q <= stage1_q;
            end
        end

        assign syncOut[i] = stage2_q;
    end

endmodule

// >>> pkg/rps_pkg.sv
// shared constants and field layouts for the reference select control block
package rps_pkg;

    localparam int          ADDR_W        = 10;                  // register address width
    localparam int          DATA_W        = 8;                   // register data width
    localparam logic [9:0]  REF_CTRL_ADDR = 10'h01c;             // reference input control
    localparam logic [9:0]  STAT_OSC_ADDR = 10'h01d;             // status and oscillator control
    localparam logic [7:0]  REF_CTRL_RST  = 8'h00;               // all fields clear after reset
    localparam logic [7:0]  STAT_OSC_RST  = 8'h80;               // eeprom status routed by default
    localparam logic [7:0]  UNMAPPED_DATA = 8'h00;               // read answer for other addresses
    localparam int          CLK_PERIOD_NS = 50;                  // clk_sys period, 20 mhz
    localparam int          DEGLITCH_NS   = 200;                 // least stable time before a switch
    localparam int          DEGLITCH_CYC  = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // reference input control register, bit 7 down to bit 0
    typedef struct packed {
        logic deglitchDis;                                       // bypass switchover deglitch
        logic selSecondary;                                      // manual register choice
        logic usePin;                                            // manual choice from select pin
        logic autoEn;                                            // automatic switchover
        logic staySecondary;                                     // non-revertive switching
        logic pwrSecondary;                                      // power secondary input
        logic pwrPrimary;                                        // power primary input
        logic diffEn;                                            // one differential reference
    } rps_ref_ctrl_t;

    // status and oscillator control register, bit 7 down to bit 0
    typedef struct packed {
        logic       eepromStatus;                                // eeprom status at status pin
        logic       xtalAmpEn;                                   // crystal amplifier enable
        logic [5:0] other;                                       // stored, not used here
    } rps_stat_osc_t;

    // what the block drives toward the reference front end
    typedef struct packed {
        logic pwrPrimary;                                        // primary input powered
        logic pwrSecondary;                                      // secondary input powered
        logic diffMode;                                          // differential input mode
        logic selSecondary;                                      // reference fed to the pll
        logic xtalAmpEn;                                         // crystal amplifier running
    } rps_front_t;

endpackage

// >>> sim/rps_ref_partner.sv
// far side: reference status lines and the external select pin
module rps_ref_partner (
    input  wire logic       clk_sys,          // system clock
    input  wire logic [2:0] cmd,              // pin, primary good, secondary good
    input  wire logic       slow,             // answer one cycle late
    output logic            refSelPin,        // select pin
    output logic            primaryGoodPin,   // primary good
    output logic            secondaryGoodPin  // secondary good
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] late_q;                       // previous command, for slow answers
    // levels change on the same edge the design samples on, through nonblocking updates, so the design sees the old level
    always @(posedge clk_sys)
    begin
        late_q <= cmd;
        {refSelPin, primaryGoodPin, secondaryGoodPin} <= slow ? late_q : cmd;
    end
endmodule

// >>> sim/rps_ref_select_properties.sv
// concurrent checks on the reference select control ports
module rps_ref_checker #(
    parameter int DEGLITCH_CYCLES = 4                      // settle count of the design
) (
    input wire logic                       clk_sys,        // system clock
    input wire logic                       srst,           // synchronous reset
    input wire logic                       regWrEn,        // write strobe
    input wire logic [rps_pkg::ADDR_W-1:0] regAddr,        // register address
    input wire logic [rps_pkg::DATA_W-1:0] regWrData,      // write data
    input wire logic                       refSelPin,      // select pin
    input wire logic                       primaryGoodPin, // primary good
    input wire logic                       eepromStatusIn, // eeprom status
    input wire logic                       statusSelIn,    // field-selected level
    input wire rps_pkg::rps_front_t        front,          // front end controls
    input wire logic                       statusPin       // status pin
);
    rps_pkg::rps_ref_ctrl_t ctl_q;                         // shadow of control register
    rps_pkg::rps_ref_ctrl_t prev_q;                        // control one cycle back
    rps_pkg::rps_stat_osc_t so_q;                          // shadow of status/osc register
    wire manReg = !ctl_q.autoEn && !ctl_q.diffEn && !ctl_q.usePin;
    wire manPin = !ctl_q.autoEn && !ctl_q.diffEn && ctl_q.usePin;
    wire autoOn = ctl_q.autoEn && !ctl_q.diffEn;
    // only the choice bit moved, so no older choice can still be pending
    wire onlySel = (ctl_q ^ prev_q) == 8'h40;
    // shadows follow writes the way the design is meant to take them
    always_ff @(posedge clk_sys)
    begin
        prev_q <= ctl_q;
        if (srst)
        begin
            ctl_q <= rps_pkg::REF_CTRL_RST;
            so_q  <= rps_pkg::STAT_OSC_RST;
        end
        else if (regWrEn && regAddr == rps_pkg::REF_CTRL_ADDR)
            ctl_q <= regWrData;
        else if (regWrEn && regAddr == rps_pkg::STAT_OSC_ADDR)
            so_q <= regWrData;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence s_reg_steady;
        (manReg && $stable(ctl_q))[*6];
    endsequence
    sequence s_pin_steady;
        (manPin && $stable(ctl_q) && $stable(refSelPin))[*8];
    endsequence
    sequence s_back_steady;
        (autoOn && !ctl_q.staySecondary && primaryGoodPin && $stable(ctl_q))[*8];
    endsequence
    sequence s_stay_held;
        (autoOn && ctl_q.staySecondary && front.selSecondary && $stable(ctl_q))[*8];
    endsequence
    a_power_gate: assert property (
        front.pwrPrimary == (ctl_q.autoEn | ctl_q.pwrPrimary) &&
        front.pwrSecondary == (ctl_q.autoEn | ctl_q.pwrSecondary))
        else $error("input power does not follow its enables");
    a_diff_mode: assert property (front.diffMode == ctl_q.diffEn)
        else $error("differential mode differs from its bit");
    a_xtal_amp: assert property (front.xtalAmpEn == so_q.xtalAmpEn)
        else $error("crystal amplifier differs from its bit");
    a_status_route: assert property (
        statusPin == (so_q.eepromStatus ? eepromStatusIn : statusSelIn))
        else $error("status pin shows the wrong source");
    a_manual_reg: assert property (s_reg_steady |-> front.selSecondary == ctl_q.selSecondary)
        else $error("register choice not applied");
    a_manual_pin: assert property (s_pin_steady |-> front.selSecondary == refSelPin)
        else $error("pin choice not applied");
    a_deglitch_hold: assert property (
        onlySel && manReg && !ctl_q.deglitchDis |-> $stable(front.selSecondary)[*3])
        else $error("choice passed before settling");
    a_deglitch_skip: assert property (
        onlySel && manReg && ctl_q.deglitchDis |=> front.selSecondary == ctl_q.selSecondary)
        else $error("bypassed choice late");
    a_revert_back: assert property (s_back_steady |-> !front.selSecondary)
        else $error("no return to primary");
    a_stay_second: assert property (s_stay_held |=> front.selSecondary)
        else $error("left secondary with stay set");
endmodule
bind rps_ref_select rps_ref_checker #(.DEGLITCH_CYCLES(DEGLITCH_CYCLES)) chk_u (
    .clk_sys(clk_sys), .srst(srst), .regWrEn(regWrEn), .regAddr(regAddr),
    .regWrData(regWrData), .refSelPin(refSelPin), .primaryGoodPin(primaryGoodPin),
    .eepromStatusIn(eepromStatusIn), .statusSelIn(statusSelIn), .front(front),
    .statusPin(statusPin));

// >>> sim/tb_rps_ref_select.sv
// self-checking bench for the reference select control block
module tb_rps_ref_select;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0, srst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0, slow = 1'b0;
    logic eepromStatusIn = 1'b0, statusSelIn = 1'b1, refSelPin, primaryGoodPin, secondaryGoodPin;
    logic [9:0] regAddr = 10'h000;
    logic [7:0] regWrData = 8'h00, regRdData;
    logic [2:0] cmd = 3'h0;
    logic       statusPin;
    logic       busy;                         // deglitch wait flag, must be low once settled
    rps_pkg::rps_front_t front;
    int failures = 0, n_checks = 0, ctl, so, st, seed = 32'hf9f295ca;
    int expQ[$];                              // expected read data, oldest first
    initial
    begin
        forever #25 clk_sys = ~clk_sys;
    end
    rps_ref_select dut_u (.clk_sys(clk_sys), .srst(srst), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .refSelPin(refSelPin),
        .primaryGoodPin(primaryGoodPin), .secondaryGoodPin(secondaryGoodPin),
        .eepromStatusIn(eepromStatusIn), .statusSelIn(statusSelIn), .front(front),
        .statusPin(statusPin), .deglitchBusy(busy));
    rps_ref_partner far_u (.clk_sys(clk_sys), .cmd(cmd), .slow(slow), .refSelPin(refSelPin),
        .primaryGoodPin(primaryGoodPin), .secondaryGoodPin(secondaryGoodPin));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (failures == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        cyc(1);
        {regAddr, regWrData, regWrEn} = {a, d, 1'b1};
        cyc(1);
        regWrEn = 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        expQ.push_back(e);
        cyc(1);
        {regAddr, regRdEn} = {a, 1'b1};
        cyc(1);
        regRdEn = 1'b0;
        check(regRdData, 8'(expQ.pop_front()));
    endtask
    // automatic choice moves one step per change of control or pins
    function automatic void upd();
        if (ctl[4] == 0)
            st = 0;
        else if (st == 0 && cmd[1:0] == 2'b01)
            st = 1;
        else if (st == 1 && cmd[1] && !ctl[3])
            st = 0;
    endfunction
    // front order: powers, diff, choice, amplifier, then status pin; diff beats auto beats manual
    function automatic logic [7:0] model();
        int sel;
        sel = ctl[0] ? 0 : ctl[4] ? st : ctl[5] ? int'(cmd[2]) : ctl[6];
        return {2'h0, ctl[4] | ctl[1], ctl[4] | ctl[2], ctl[0], sel[0], so[6],
                so[7] ? eepromStatusIn : statusSelIn};
    endfunction
    task automatic settle(input logic [7:0] c, input logic [5:0] p);
        wr(rps_pkg::REF_CTRL_ADDR, c);
        ctl = c;
        upd();
        {eepromStatusIn, statusSelIn, slow, cmd} = p;
        upd();
        cyc(14);
        check({1'b0, busy, front, statusPin}, model());
        rd(rps_pkg::REF_CTRL_ADDR, c);
        rd(rps_pkg::STAT_OSC_ADDR, 8'(so));
    endtask
    task automatic hit();
        cyc(1);
        srst = 1'b1;
        cyc(12);
        srst = 1'b0;
        {ctl, so, st} = {32'd0, 32'(rps_pkg::STAT_OSC_RST), 32'd0};
        check({2'h0, front, statusPin}, model());
        rd(rps_pkg::REF_CTRL_ADDR, 8'h00);
        rd(rps_pkg::STAT_OSC_ADDR, 8'h80);
    endtask
    initial
    begin
        logic [31:0] r;
        logic [7:0]  c;
        hit();
        wr(10'h01e, 8'hff);
        rd(10'h3ff, 8'h00);
        repeat (60)
        begin
            r = $random(seed);
            c = r[7:0];
            if (c[4]) c[0] = 1'b0;
            if (c[0]) c[2:1] = 2'b00;
            wr(rps_pkg::STAT_OSC_ADDR, r[15:8]);
            so = r[15:8];
            settle(c, r[21:16]);
            settle(c ^ 8'h40, r[21:16]);
        end
        hit();
        conclude();
    end
    // a hang is cut short well past the expected length of the run
    initial
    begin
        cyc(20000);
        failures++;
        conclude();
    end
endmodule
